/* File: core/usart_tx.sv */
/*
  Serial transmitter with buffer-empty and transmit-complete flags,
  frame format control and master SPI transfer clock output, on APB.
  Assumes synchronous inputs on pclk and a zero-wait APB master.
*/
`timescale 1ns/1ps
module usart_tx
  import usart_tx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic global_irq_enable,
  input wire logic done_irq_ack,
  input wire logic xck_dir_out,
  output serial_out_t ser_out,
  output logic empty_irq_req,
  output logic done_irq_req,
  output logic irq
);
  logic [8:0] buf_reg;
  logic buf_full_reg;
  logic done_reg;
  logic [7:0] csb_reg;
  frame_fmt_t ffc_reg;
  logic [BAUD_W-1:0] baud_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [IRQ_W-1:0] stat_read_reg;
  tx_state_t state_reg;
  logic [8:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic half_reg;
  logic par_reg;
  logic [BAUD_W-1:0] baud_cnt_reg;
  logic txd_reg;
  logic xck_reg;

  logic setup_ph;
  logic wr_acc;
  logic rd_acc;
  logic data_wr;
  logic spi_mode;
  logic tick;
  logic load;
  logic frame_end;
  logic [2:0] size_sel;
  logic [3:0] nbits;
  logic [1:0] parity_sel;
  logic [31:0] rd_mux;
  logic rd_hit;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign data_wr = wr_acc && (paddr == OFF_DATA);
  assign pready = penable;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && psel && penable;

  assign spi_mode = (ffc_reg.mode == MODE_MASTER_SPI) && xck_dir_out;
  assign size_sel = {csb_reg[CSB_SIZE2], ffc_reg.size};
  always_comb
  begin
    if (spi_mode)
      nbits = BITS_SPI;
    else if (size_sel == SIZE_NINE)
      nbits = BITS_NINE;
    else
      nbits = BITS_BASE + {2'b00, ffc_reg.size};
  end
  // Reserved code 01 is treated as no parity
  assign parity_sel = (ffc_reg.parity[1] && !spi_mode) ? ffc_reg.parity : PAR_OFF;

  assign tick = (baud_cnt_reg == '0);
  assign load = (state_reg == ST_IDLE) && buf_full_reg && csb_reg[CSB_TX_ENABLE];

  // Read mux, captured in setup so prdata comes from a flop
  always_comb
  begin
    rd_mux = '0;
    rd_hit = 1'b1;
    if (paddr == OFF_DATA)
      rd_mux = '0;
    else if (paddr == OFF_CSA)
    begin
      rd_mux[CSA_DONE] = done_reg;
      rd_mux[CSA_EMPTY] = !buf_full_reg;
    end
    else if (paddr == OFF_CSB)
      rd_mux[7:0] = csb_reg;
    else if (paddr == OFF_FFC)
      rd_mux[7:0] = ffc_reg;
    else if (paddr == OFF_BAUD)
      rd_mux[BAUD_W-1:0] = baud_reg;
    else if (paddr == OFF_IRQ_STAT)
      rd_mux[IRQ_W-1:0] = irq_stat_reg;
    else if (paddr == OFF_IRQ_MASK)
      rd_mux[IRQ_W-1:0] = irq_mask_reg;
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
      stat_read_reg <= '0;
    end
    else if (setup_ph)
    begin
      prdata_reg <= rd_mux;
      pslverr_reg <= !rd_hit;
      stat_read_reg <= (paddr == OFF_IRQ_STAT && !pwrite) ? irq_stat_reg : '0;
    end
  end

  // Control registers; bit 5 of register A is never stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      csb_reg <= CSB_RESET;
      ffc_reg <= FFC_RESET;
      baud_reg <= BAUD_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
    end
    else if (wr_acc)
    begin
      if (paddr == OFF_CSB)
        csb_reg <= pwdata[7:0];
      else if (paddr == OFF_FFC)
        ffc_reg <= pwdata[7:0];
      else if (paddr == OFF_BAUD)
        baud_reg <= pwdata[BAUD_W-1:0];
      else if (paddr == OFF_IRQ_MASK)
        irq_mask_reg <= pwdata[IRQ_W-1:0];
    end
  end

  // Transmit buffer; a write while full overwrites the waiting data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buf_reg <= '0;
      buf_full_reg <= 1'b0;
    end
    else if (data_wr)
    begin
      buf_reg <= {csb_reg[CSB_NINTH], pwdata[7:0]};
      buf_full_reg <= 1'b1;
    end
    else if (load)
      buf_full_reg <= 1'b0;
  end

  // Complete flag: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_reg <= 1'b0;
    else if (frame_end && !buf_full_reg && !data_wr)
      done_reg <= 1'b1;
    else if (done_irq_ack && done_irq_req)
      done_reg <= 1'b0;
    else if (wr_acc && paddr == OFF_CSA && pwdata[CSA_DONE])
      done_reg <= 1'b0;
  end

  // Sticky status; only bits seen by the read are cleared
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_reg <= '0;
    else
    begin
      irq_stat_reg <= (irq_stat_reg & ~(rd_acc ? stat_read_reg : '0))
                      | {frame_end && !buf_full_reg && !data_wr, load};
    end
  end

  assign empty_irq_req = !buf_full_reg && csb_reg[CSB_EMPTY_IE] && global_irq_enable;
  assign done_irq_req = done_reg && csb_reg[CSB_DONE_IE] && global_irq_enable;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Bit timer: one tick per async bit or per SPI half bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      baud_cnt_reg <= '0;
    else if (load || tick)
      baud_cnt_reg <= baud_reg;
    else
      baud_cnt_reg <= baud_cnt_reg - 1'b1;
  end

  assign frame_end = tick && (((state_reg == ST_STOP) && (bit_cnt_reg[0] == ffc_reg.stop2))
                   || ((state_reg == ST_DATA) && spi_mode && half_reg
                   && (bit_cnt_reg == nbits - 4'h1)));

  // Shifter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      shift_reg <= '0;
      bit_cnt_reg <= '0;
      half_reg <= 1'b0;
      par_reg <= 1'b0;
      txd_reg <= 1'b1;
      xck_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          xck_reg <= ffc_reg.pol;
          if (load)
          begin
            shift_reg <= buf_reg;
            bit_cnt_reg <= '0;
            half_reg <= 1'b0;
            par_reg <= 1'b0;
            if (spi_mode)
            begin
              state_reg <= ST_DATA;
              if (!ffc_reg.size[0])
                txd_reg <= buf_reg[0];
            end
            else
            begin
              state_reg <= ST_START;
              txd_reg <= 1'b0;
            end
          end
          else if (!spi_mode)
            txd_reg <= 1'b1;
        end
        ST_START:
          if (tick)
          begin
            state_reg <= ST_DATA;
            txd_reg <= shift_reg[0];
          end
        ST_DATA:
          if (tick && spi_mode)
          begin
            // Clock phase reuses the low size bit in master SPI
            half_reg <= !half_reg;
            if (!half_reg)
            begin
              xck_reg <= !ffc_reg.pol;
              if (ffc_reg.size[0])
                txd_reg <= shift_reg[0];
            end
            else
            begin
              xck_reg <= ffc_reg.pol;
              shift_reg <= shift_reg >> 1;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (!ffc_reg.size[0])
                txd_reg <= shift_reg[1];
              if (bit_cnt_reg == nbits - 4'h1)
                state_reg <= ST_IDLE;
            end
          end
          else if (tick)
          begin
            par_reg <= par_reg ^ shift_reg[0];
            shift_reg <= shift_reg >> 1;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == nbits - 4'h1)
            begin
              bit_cnt_reg <= '0;
              if (parity_sel != PAR_OFF)
              begin
                state_reg <= ST_PARITY;
                txd_reg <= par_reg ^ shift_reg[0] ^ (parity_sel == PAR_ODD);
              end
              else
              begin
                state_reg <= ST_STOP;
                txd_reg <= 1'b1;
              end
            end
            else
              txd_reg <= shift_reg[1];
          end
        ST_PARITY:
          if (tick)
          begin
            state_reg <= ST_STOP;
            txd_reg <= 1'b1;
          end
        ST_STOP:
          if (tick)
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg[0] == ffc_reg.stop2)
              state_reg <= ST_IDLE;
          end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  assign ser_out.txd = txd_reg;
  assign ser_out.xck_o = xck_reg;
  assign ser_out.xck_oe = spi_mode;
endmodule

/* File: core/usart_tx_pkg.sv */
/*
  Constants, field layouts and types of the serial transmitter block.
  Assumes an APB slave with 32-bit data and 8-bit byte addresses.
*/
package usart_tx_pkg;
  localparam int ADDR_W = 8;
  localparam int BAUD_W = 12;
  localparam int IRQ_W = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CSA = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CSB = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FFC = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_BAUD = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h18;

  // ctrl_status_a bit positions
  localparam int CSA_DONE = 6;
  localparam int CSA_EMPTY = 5;

  // ctrl_status_b bit positions
  localparam int CSB_DONE_IE = 6;
  localparam int CSB_EMPTY_IE = 5;
  localparam int CSB_RX_ENABLE = 4;
  localparam int CSB_TX_ENABLE = 3;
  localparam int CSB_SIZE2 = 2;
  localparam int CSB_NINTH = 0;

  // Interrupt status bit positions
  localparam int IRQ_EMPTY = 0;
  localparam int IRQ_DONE = 1;

  // Reset values
  localparam logic [7:0] CSB_RESET = 8'h00;
  localparam logic [7:0] FFC_RESET = 8'h06;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 12'h000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

  // Field encodings
  localparam logic [1:0] PAR_OFF = 2'b00;
  localparam logic [1:0] PAR_ODD = 2'b11;
  localparam logic [1:0] MODE_MASTER_SPI = 2'b11;
  localparam logic [2:0] SIZE_NINE = 3'b111;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [3:0] BITS_BASE = 4'h5;
  localparam logic [3:0] BITS_SPI = 4'h8;

  // frame_format_control layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] parity;
    logic stop2;
    logic [1:0] size;
    logic pol;
  } frame_fmt_t;

  typedef struct packed {
    logic txd;
    logic xck_o;
    logic xck_oe;
  } serial_out_t;

  typedef enum {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} tx_state_t;
endpackage

/* File: test/serial_node_model.sv */
/*
  Remote asynchronous node: decodes frames seen on the serial line.
  Assumes bit time in whole clock cycles, set before each frame.
*/
`timescale 1ns/1ps
module serial_node_model
(
  input wire logic clk,
  input wire logic txd,
  input wire logic [31:0] bit_cyc,
  input wire logic [31:0] nbits,
  input wire logic [1:0] par,
  input wire logic stop2,
  output logic [8:0] word,
  output logic frame_ok,
  output int frames
);
  int i;
  logic p;
  initial
  begin
    frames = 0;
    word = 9'h0;
    frame_ok = 1'b0;
    forever
    begin
      @(posedge clk);
      if (txd === 1'b0)
      begin
        // Mid-bit sampling tolerates a one-cycle phase slip only when bit_cyc is 3 or more
        repeat (bit_cyc / 2) @(posedge clk);
        frame_ok = (txd === 1'b0);
        word = 9'h0;
        for (i = 0; i < nbits; i++)
        begin
          repeat (bit_cyc) @(posedge clk);
          word[i] = txd;
        end
        p = ^word ^ par[0];
        if (par[1])
        begin
          repeat (bit_cyc) @(posedge clk);
          frame_ok = frame_ok & (txd === p);
        end
        repeat (stop2 ? 2 : 1)
        begin
          repeat (bit_cyc) @(posedge clk);
          frame_ok = frame_ok & (txd === 1'b1);
        end
        frames++;
      end
    end
  end
endmodule

/* File: test/usart_tx_assertions.sv */
/*
  Port checker of the serial transmitter.
  Assumes it sees only the top ports; bound at the foot.
*/
`timescale 1ns/1ps
module usart_tx_assertions
  import usart_tx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_irq_enable,
  input wire logic done_irq_ack,
  input wire logic xck_dir_out,
  input wire serial_out_t ser_out,
  input wire logic empty_irq_req,
  input wire logic done_irq_req,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr = psel && penable && pwrite;
  chk_ready_zero_wait:
    assert property (psel && penable |-> pready)
    else $error("pready missing in access");
  chk_irq_global_gate:
    assert property (!global_irq_enable |-> !empty_irq_req && !done_irq_req)
    else $error("request without global enable");
  chk_data_wr_clears:
    assert property (wr && paddr == OFF_DATA |=> !empty_irq_req)
    else $error("empty request after data write");
  chk_empty_holds:
    assert property (empty_irq_req && !wr |=> empty_irq_req || !global_irq_enable)
    else $error("empty request dropped");
  chk_ack_clears:
    assert property (done_irq_ack && done_irq_req |=> !done_irq_req)
    else $error("done request after service");
  chk_one_clears:
    assert property (wr && paddr == OFF_CSA && pwdata[CSA_DONE] |=> !done_irq_req)
    else $error("done request after clear");
  chk_idle_high:
    assert property ($rose(presetn) |-> ser_out.txd)
    else $error("serial line not idle high");
  chk_clk_out_dir:
    assert property (ser_out.xck_oe |-> xck_dir_out)
    else $error("clock driven while pin is input");
  chk_unmapped_err:
    assert property (psel && penable && paddr > OFF_IRQ_MASK |-> pslverr)
    else $error("no error on unmapped access");
  cover property (done_irq_ack && done_irq_req);
  cover property ($rose(ser_out.xck_oe));
  cover property (irq && empty_irq_req);
endmodule
bind usart_tx usart_tx_assertions i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .global_irq_enable(global_irq_enable), .done_irq_ack(done_irq_ack),
  .xck_dir_out(xck_dir_out), .ser_out(ser_out), .empty_irq_req(empty_irq_req),
  .done_irq_req(done_irq_req), .irq(irq)
);

/* File: test/usart_tx_flags_frame_format_bench.sv */
/*
  Self-checking bench of the serial transmitter.
  Assumes an APB master here and a serial node model on the line.
*/
`timescale 1ns/1ps
module usart_tx_flags_frame_format_bench
  import usart_tx_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, global_irq_enable, done_irq_ack, xck_dir_out;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, empty_irq_req, done_irq_req, irq, fok, stp;
  serial_out_t ser_out;
  logic [8:0] word, dat;
  logic [1:0] par;
  logic [2:0] sz;
  int fail_count = 0, checks = 0, frames, nb = 8, bc = 1, n, cnt;
  logic [7:0] offs[5] = '{OFF_CSA, OFF_CSB, OFF_FFC, OFF_BAUD, OFF_IRQ_MASK};
  logic [31:0] rstv[5] = '{32'h20, 32'h0, 32'h6, 32'h0, 32'h0};
  usart_tx i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_irq_enable(global_irq_enable), .done_irq_ack(done_irq_ack),
    .xck_dir_out(xck_dir_out), .ser_out(ser_out), .empty_irq_req(empty_irq_req),
    .done_irq_req(done_irq_req), .irq(irq));
  serial_node_model i_node (.clk(pclk), .txd(ser_out.txd), .bit_cyc(bc), .nbits(nb),
    .par(par), .stop2(stp), .word(word), .frame_ok(fok), .frames(frames));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // Taken at the rising edge; flops update only after this read
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50)
    begin
      @(posedge pclk);
      k++;
    end
    if (k >= 50)
    begin
      fail_count++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic await_done(input int tgt);
    n = 0;
    while ((frames < tgt || done_irq_req !== 1'b1) && n < 500)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500)
    begin
      fail_count++;
      finish_test();
    end
  endtask
  initial
  begin
    void'($urandom(16923));
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {done_irq_ack, xck_dir_out, par, sz, stp, dat} = '0;
    global_irq_enable = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 32'h0);
      check(rd, rstv[i]);
    end
    apb(1'b0, 8'h1C, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, OFF_IRQ_MASK, 32'h3);
    apb(1'b1, OFF_BAUD, 32'h0);
    apb(1'b1, OFF_CSB, 32'h78);
    bc = $urandom_range(3) + 1;
    apb(1'b1, OFF_BAUD, 32'(bc - 1));
    for (int j = 0; j < 8; j++)
    begin
      par = 2'(j);
      sz = (j % 3 == 0) ? 3'h7 : 3'($urandom_range(3));
      stp = 1'($urandom_range(1));
      dat = 9'($urandom);
      nb = (sz == 3'h7) ? 9 : sz + 5;
      apb(1'b1, OFF_FFC, {24'h0, 2'b00, par, stp, sz[1:0], 1'b0});
      apb(1'b1, OFF_CSB, {25'h0, 4'hF, sz[2], 1'b0, dat[8]});
      check({31'h0, empty_irq_req}, 32'h1);
      apb(1'b1, OFF_DATA, {24'h0, dat[7:0]});
      await_done(j + 1);
      check({23'h0, word}, {23'h0, dat & 9'((1 << nb) - 1)});
      check({31'h0, fok}, 32'h1);
      check({31'h0, irq}, 32'h1);
      apb(1'b0, OFF_CSA, 32'h0);
      check(rd, 32'h60);
      apb(1'b1, OFF_CSB, {25'h0, 4'h7, sz[2], 1'b0, dat[8]});
      check({31'h0, done_irq_req}, 32'h0);
      apb(1'b1, OFF_CSB, {25'h0, 4'hF, sz[2], 1'b0, dat[8]});
      apb(1'b0, OFF_IRQ_STAT, 32'h0);
      check(rd, 32'h3);
      check({31'h0, irq}, 32'h0);
      if (j % 2 == 1)
        apb(1'b1, OFF_CSA, 32'h40);
      else
      begin
        done_irq_ack <= 1'b1;
        @(posedge pclk);
        done_irq_ack <= 1'b0;
        @(posedge pclk);
      end
      check({31'h0, done_irq_req}, 32'h0);
      global_irq_enable <= 1'b0;
      @(posedge pclk);
      check({31'h0, empty_irq_req}, 32'h0);
      global_irq_enable <= 1'b1;
    end
    apb(1'b1, OFF_FFC, 32'hC0);
    check({31'h0, ser_out.xck_oe}, 32'h0);
    xck_dir_out <= 1'b1;
    @(posedge pclk);
    check({31'h0, ser_out.xck_oe}, 32'h1);
    apb(1'b1, OFF_DATA, 32'hA5);
    n = 0;
    cnt = 0;
    repeat (200)
    begin
      @(negedge pclk);
      cnt += (ser_out.xck_o === 1'b1 && n == 0);
      n = (ser_out.xck_o === 1'b1);
    end
    check(32'(cnt), 32'h8);
    finish_test();
  end
endmodule
